// >>> rtl/tcount_regs.svh
// Register map and constants of the sixteen-bit timer core
`ifndef TCOUNT_REGS_SVH
`define TCOUNT_REGS_SVH
`define OFS_COUNT_LOW 12'h000
`define OFS_COUNT_HIGH 12'h004
`define OFS_CONTROL 12'h008
`define OFS_GATE_CONTROL 12'h00c
`define OFS_STATUS 12'h010
`define CTL_ON_BIT 0
`define CTL_SYNC_N_BIT 2
`define CTL_OSC_EN_BIT 3
`define CTL_PS_LSB 4
`define CTL_CS_LSB 6
`define GCTL_GATE_EN_BIT 7
`define STAT_OVF_BIT 0
`define CONTROL_RESET 8'h00
`define INSTR_DIV 3'h4
`define COUNT_MAX 16'hffff
`endif

// >>> rtl/tcount_pkg.sv
// Types of the sixteen-bit timer core
package tcount_pkg;
  typedef enum logic [1:0] {
    SRC_INSTR,
    SRC_SYSTEM,
    SRC_EXTERNAL,
    SRC_LFOSC
  } clk_src_t;
  typedef logic [7:0] byte_t;
endpackage

// >>> rtl/edge_sync.sv
// Two-stage synchroniser with rising and falling edge pulses
`timescale 1ns/1ps
module edge_sync (
  input wire logic clk,
  input wire logic rst,
  input wire logic async_in,
  output logic level,
  output logic rise,
  output logic fall
);
  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
  } sync_state_t;
  sync_state_t s_q, s_d;
  always_comb begin
    s_d = s_q;
    s_d.meta = async_in;
    s_d.sync = s_q.meta;
    s_d.prev = s_q.sync;
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign level = s_q.sync;
  assign rise = s_q.sync & ~s_q.prev;
  assign fall = ~s_q.sync & s_q.prev;
endmodule // edge_sync

// >>> rtl/timer16_core.sv
// Sixteen-bit timer/counter core with APB register access
// Contract
// - 16-bit up-counter as high and low bytes; writes replace the live byte at once.
// - Internal source ticks per instruction cycle; external source ticks per rising edge.
// - Off when on bit 0; always counts when gate bit 0; else gated.
// - Source field: 11 low-freq osc, 01 system, 00 instruction, 10 external pin (secondary osc when osc enable is set).
// - System clock source advances four times per instruction cycle.
// - External pin counts on rising edge, always synchronised; the sync bit is only stored and read back.
// - External mode needs a falling edge before the first counted rising edge.
// - Prescaler divides selected clock by 1, 2, 4 or 8.
// - Prescaler is hidden from software and cleared by any count byte write.
// - Oscillator-enable bit starts the secondary oscillator; it runs during sleep.
// - Rollover from ffff to 0000 sets overflow flag until software clears it.
`timescale 1ns/1ps
`include "tcount_regs.svh"
module timer16_core #(
  parameter int PS_WIDTH = 3
) (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RST,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Clock sources from outside the core domain
  input wire logic EXTERNAL_CLOCK_PIN,
  input wire logic SECONDARY_OSC_CLK,
  input wire logic LOW_FREQ_INTERNAL_OSC,
  // Gate logic, oscillator control and overflow flag
  input wire logic GATE_PERMIT,
  output logic SECONDARY_OSC_ENABLE,
  output logic GATE_ENABLE_BIT,
  output logic OVERFLOW_FLAG
);
  import tcount_pkg::*;

  typedef struct packed {
    logic [15:0] count;
    logic [PS_WIDTH-1:0] prescale;
    logic [1:0] instr_div;
    logic counter_on_bit;
    logic sync_n;
    logic secondary_osc_enable;
    logic [1:0] prescale_select;
    clk_src_t clock_source_select;
    logic gate_enable_bit;
    logic overflow_flag;
    logic fall_seen;
    logic ready;
    logic [31:0] rdata;
  } core_state_t;

  core_state_t s_q, s_d;

  logic pin_level, pin_rise, pin_fall;
  logic osc_level, osc_rise, osc_fall;
  logic lf_level, lf_rise, lf_fall;
  logic apb_access, apb_wr, apb_rd, addr_ok;
  logic wr_low, wr_high, wr_ctl, wr_gctl, wr_stat;
  logic run, ext_mode, src_tick, ps_tick;
  logic [PS_WIDTH-1:0] ps_limit;

  // External clock inputs are sampled through two flops before use; GATE_PERMIT is used directly
  edge_sync u_pin_sync (
    .clk(CORE_CLK),
    .rst(RST),
    .async_in(EXTERNAL_CLOCK_PIN),
    .level(pin_level),
    .rise(pin_rise),
    .fall(pin_fall)
  );
  edge_sync u_osc_sync (
    .clk(CORE_CLK),
    .rst(RST),
    .async_in(SECONDARY_OSC_CLK),
    .level(osc_level),
    .rise(osc_rise),
    .fall(osc_fall)
  );
  edge_sync u_lf_sync (
    .clk(CORE_CLK),
    .rst(RST),
    .async_in(LOW_FREQ_INTERNAL_OSC),
    .level(lf_level),
    .rise(lf_rise),
    .fall(lf_fall)
  );

  assign apb_access = PSEL & PENABLE;
  // Writes land on the completing edge; reads are captured one edge earlier
  assign apb_wr = apb_access & s_q.ready & PWRITE & PSTRB[0];
  assign apb_rd = apb_access & ~s_q.ready & ~PWRITE;
  always_comb begin
    case (PADDR)
      `OFS_COUNT_LOW, `OFS_COUNT_HIGH, `OFS_CONTROL, `OFS_GATE_CONTROL, `OFS_STATUS: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end
  assign wr_low = apb_wr & (PADDR == `OFS_COUNT_LOW);
  assign wr_high = apb_wr & (PADDR == `OFS_COUNT_HIGH);
  assign wr_ctl = apb_wr & (PADDR == `OFS_CONTROL);
  assign wr_gctl = apb_wr & (PADDR == `OFS_GATE_CONTROL);
  assign wr_stat = apb_wr & (PADDR == `OFS_STATUS);

  // Enable table: off, always on, or gated
  assign run = s_q.counter_on_bit & (~s_q.gate_enable_bit | GATE_PERMIT);
  assign ext_mode = (s_q.clock_source_select == SRC_EXTERNAL);

  // Source decode; all sources reduce to one-cycle ticks of the core clock
  always_comb begin
    case (s_q.clock_source_select)
      SRC_LFOSC: src_tick = lf_rise;
      // Four ticks per instruction cycle, so reads carry two LSBs of uncertainty
      SRC_SYSTEM: src_tick = 1'b1;
      SRC_INSTR: src_tick = (s_q.instr_div == 2'(`INSTR_DIV - 3'h1));
      SRC_EXTERNAL: src_tick = (s_q.secondary_osc_enable ? osc_rise : pin_rise) & s_q.fall_seen;
      default: src_tick = 1'b0;
    endcase
  end

  // Prescaler outputs one tick per 1, 2, 4 or 8 source ticks
  assign ps_limit = PS_WIDTH'((1 << s_q.prescale_select) - 1);
  assign ps_tick = run & src_tick & (s_q.prescale == ps_limit);

  always_comb begin
    s_d = s_q;
    s_d.instr_div = s_q.instr_div + 2'h1;
    s_d.ready = apb_access & ~s_q.ready;
    if (run & src_tick) begin
      s_d.prescale = (s_q.prescale == ps_limit) ? '0 : s_q.prescale + PS_WIDTH'(1);
    end
    if (ps_tick) begin
      s_d.count = s_q.count + 16'h0001;
      if (s_q.count == `COUNT_MAX) begin
        s_d.overflow_flag = 1'b1;
      end
    end
    // Arm the rising-edge qualifier only after a falling edge of the counted input
    if (ext_mode && (s_q.secondary_osc_enable ? osc_fall : pin_fall)) begin
      s_d.fall_seen = 1'b1;
    end
    if (!s_q.counter_on_bit) begin
      s_d.fall_seen = 1'b0;
    end
    if (wr_low) begin
      s_d.count[7:0] = PWDATA[7:0];
      s_d.prescale = '0;
      s_d.fall_seen = 1'b0;
    end
    if (wr_high) begin
      s_d.count[15:8] = PWDATA[7:0];
      s_d.prescale = '0;
      s_d.fall_seen = 1'b0;
    end
    if (wr_ctl) begin
      s_d.counter_on_bit = PWDATA[`CTL_ON_BIT];
      s_d.sync_n = PWDATA[`CTL_SYNC_N_BIT];
      s_d.secondary_osc_enable = PWDATA[`CTL_OSC_EN_BIT];
      s_d.prescale_select = PWDATA[`CTL_PS_LSB +: 2];
      s_d.clock_source_select = clk_src_t'(PWDATA[`CTL_CS_LSB +: 2]);
    end
    if (wr_gctl) begin
      s_d.gate_enable_bit = PWDATA[`GCTL_GATE_EN_BIT];
    end
    // Write one to clear; a same-cycle rollover still wins
    if (wr_stat && PWDATA[`STAT_OVF_BIT] && !(ps_tick && s_q.count == `COUNT_MAX)) begin
      s_d.overflow_flag = 1'b0;
    end
    s_d.rdata = 32'h0000_0000;
    if (apb_rd) begin
      case (PADDR)
        `OFS_COUNT_LOW: s_d.rdata[7:0] = s_q.count[7:0];
        `OFS_COUNT_HIGH: s_d.rdata[7:0] = s_q.count[15:8];
        `OFS_CONTROL: s_d.rdata[7:0] = {s_q.clock_source_select, s_q.prescale_select,
          s_q.secondary_osc_enable, s_q.sync_n, 1'b0, s_q.counter_on_bit};
        `OFS_GATE_CONTROL: s_d.rdata[7:0] = {s_q.gate_enable_bit, 7'h00};
        `OFS_STATUS: s_d.rdata[7:0] = {7'h00, s_q.overflow_flag};
        default: s_d.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // One wait state so that read data can come straight from a flop
  assign PREADY = s_q.ready;
  assign PSLVERR = apb_access & s_q.ready & ~addr_ok;
  assign PRDATA = s_q.rdata;
  assign SECONDARY_OSC_ENABLE = s_q.secondary_osc_enable;
  assign GATE_ENABLE_BIT = s_q.gate_enable_bit;
  assign OVERFLOW_FLAG = s_q.overflow_flag;
endmodule // timer16_core

// >>> testbench/ext_clock_model.sv
// Far-side clock source: pin, crystal or slow oscillator
`timescale 1ns/1ps
module ext_clock_model #(
  parameter int HALF = 130
) (
  // Clock line
  output logic pin
);
  // Rests low between bursts, so every burst starts with a rise
  initial pin = 1'b0;
  task automatic pulses(input int n);
    repeat (n) begin
      #(HALF) pin = 1'b1;
      #(HALF) pin = 1'b0;
    end
  endtask
endmodule // ext_clock_model

// >>> testbench/timer16_core_assertions.sv
// Port checker of the timer core
`timescale 1ns/1ps
module timer16_core_assertions (
  // Clock, reset and APB
  input wire logic CORE_CLK, RST, PSEL, PENABLE, PWRITE, PREADY,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA, PRDATA,
  input wire logic [3:0] PSTRB,
  // Control outputs
  input wire logic SECONDARY_OSC_ENABLE, GATE_ENABLE_BIT, OVERFLOW_FLAG
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  wire rd = PSEL && PENABLE && PREADY && !PWRITE;
  wire wr = PSEL && PENABLE && PREADY && PWRITE && PSTRB[0];
  a_osc_follow: assert property (wr && PADDR == 12'h008 |=>
    SECONDARY_OSC_ENABLE == $past(PWDATA[3])) else $error("osc enable not written");
  a_osc_hold: assert property (!(wr && PADDR == 12'h008) |=> $stable(SECONDARY_OSC_ENABLE))
    else $error("osc enable moved");
  a_gate_follow: assert property (wr && PADDR == 12'h00c |=> GATE_ENABLE_BIT == $past(PWDATA[7]))
    else $error("gate bit not written");
  a_gate_hold: assert property (!(wr && PADDR == 12'h00c) |=> $stable(GATE_ENABLE_BIT))
    else $error("gate bit moved");
  a_flag_sticky: assert property (OVERFLOW_FLAG && !(wr && PADDR == 12'h010 && PWDATA[0]) |=> OVERFLOW_FLAG)
    else $error("flag lost");
  a_flag_read: assert property (rd && PADDR == 12'h010 |-> PRDATA[0] == $past(OVERFLOW_FLAG))
    else $error("flag read wrong");
  a_ctrl_read: assert property (rd && PADDR == 12'h008 |->
    PRDATA[31:8] == 24'h0 && PRDATA[3] == $past(SECONDARY_OSC_ENABLE)) else $error("control read wrong");
  a_byte_read: assert property (rd && PADDR[11:3] == 9'h0 |-> PRDATA[31:8] == 24'h0)
    else $error("count byte wide");
endmodule // timer16_core_assertions
bind timer16_core timer16_core_assertions u_chk (.CORE_CLK, .RST, .PSEL, .PENABLE, .PWRITE, .PREADY, .PADDR,
  .PWDATA, .PRDATA, .PSTRB, .SECONDARY_OSC_ENABLE, .GATE_ENABLE_BIT, .OVERFLOW_FLAG);

// >>> testbench/sixteen_bit_timer_core_tb_top.sv
// Self-checking bench of the timer core
`timescale 1ns/1ps
module sixteen_bit_timer_core_tb_top;
  logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, gate = 1;
  logic [11:0] pa = 0;
  logic [31:0] pwd = 0, prd, r;
  logic [3:0] pst = 4'hf;
  logic [15:0] c;
  logic pin, osc, lfo, rdy, err, oen, gen, ovf, e;
  int errors = 0, n_compared = 0;
  always #25 clk = ~clk;
  ext_clock_model u_pin (.pin(pin));
  ext_clock_model u_osc (.pin(osc));
  ext_clock_model u_lfo (.pin(lfo));
  timer16_core #(.PS_WIDTH(3)) u_dut (.CORE_CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(pen),
    .PWRITE(pwr), .PADDR(pa), .PWDATA(pwd), .PSTRB(pst), .PRDATA(prd), .PREADY(rdy), .PSLVERR(err),
    .EXTERNAL_CLOCK_PIN(pin), .SECONDARY_OSC_CLK(osc), .LOW_FREQ_INTERNAL_OSC(lfo), .GATE_PERMIT(gate),
    .SECONDARY_OSC_ENABLE(oen), .GATE_ENABLE_BIT(gen), .OVERFLOW_FLAG(ovf));
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1;
    // Waits for ready however long it takes; only the watchdog ends a hang
    do @(posedge clk); while (rdy !== 1'b1);
    r = prd;
    e = err;
    psel <= 0;
    pen <= 0;
  endtask
  task automatic chk(input logic [31:0] got, input int lo, hi);
    n_compared++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      errors++;
      $display("MISMATCH at %0t: got %0h want %0h..%0h", $time, got, lo, hi);
    end
  endtask
  task automatic wr_cnt(input logic [15:0] v);
    apb(1, 12'h000, {24'h0, v[7:0]});
    apb(1, 12'h004, {24'h0, v[15:8]});
  endtask
  task automatic rd_cnt();
    apb(0, 12'h000, 0);
    c[7:0] = r[7:0];
    apb(0, 12'h004, 0);
    c[15:8] = r[7:0];
  endtask
  task automatic run(input logic [7:0] ctl, input int k, n, cyc, lo, hi);
    wr_cnt(0);
    apb(1, 12'h008, {24'h0, ctl});
    if (k == 1) u_pin.pulses(n);
    else if (k == 2) u_osc.pulses(n);
    else if (k == 3) u_lfo.pulses(n);
    repeat (cyc) @(posedge clk);
    apb(1, 12'h008, {24'h0, ctl & 8'hfe});
    rd_cnt();
    chk(c, lo, hi);
  endtask
  task automatic t_regs();
    apb(0, 12'h008, 0);
    chk(r, 0, 0);
    chk(e, 0, 0);
    wr_cnt(16'ha55a);
    rd_cnt();
    chk(c, 16'ha55a, 16'ha55a);
    apb(0, 12'h014, 0);
    chk(r, 0, 0);
    chk(e, 1, 1);
    @(posedge clk) pst <= 4'he;
    apb(1, 12'h008, 32'h8);
    @(posedge clk) pst <= 4'hf;
    chk(oen, 0, 0);
    apb(1, 12'h008, 32'h8);
    @(negedge clk);
    chk(oen, 1, 1);
    apb(1, 12'h00c, 32'h80);
    @(negedge clk);
    chk(gen, 1, 1);
    $display("t_regs done");
  endtask
  task automatic t_src();
    for (int p = 0; p < 4; p++) begin
      run({2'b01, p[1:0], 4'h1}, 0, 0, 97, (100 >> p) - 2, (100 >> p) + 2);
      run({2'b00, p[1:0], 4'h1}, 0, 0, 97, (25 >> p) - 2, (25 >> p) + 2);
    end
    run(8'h81, 1, 5, 10, 4, 4);
    run(8'h89, 1, 5, 10, 0, 0);
    run(8'h89, 2, 5, 10, 4, 5);
    run(8'hc1, 3, 5, 10, 4, 5);
    $display("t_src done");
  endtask
  task automatic t_gate();
    @(posedge clk) gate <= 0;
    run(8'h41, 0, 0, 97, 0, 0);
    apb(1, 12'h00c, 0);
    run(8'h41, 0, 0, 97, 98, 102);
    $display("t_gate done");
  endtask
  task automatic t_ovf();
    int t = 0;
    apb(1, 12'h010, 1);
    wr_cnt(16'hfc00);
    apb(1, 12'h008, 32'h41);
    chk(ovf, 0, 0);
    while (ovf !== 1'b1 && t++ < 1100) @(negedge clk);
    chk(t, 1018, 1030);
    apb(1, 12'h008, 0);
    repeat (5) @(posedge clk);
    chk(ovf, 1, 1);
    apb(1, 12'h010, 1);
    @(negedge clk);
    chk(ovf, 0, 0);
    $display("t_ovf done");
  endtask
  task automatic print_verdict();
    $display("compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst <= 0;
    t_regs();
    t_src();
    t_gate();
    t_ovf();
    print_verdict();
  end
  initial begin
    #(50 * 30000);
    errors++;
    print_verdict();
  end
endmodule // sixteen_bit_timer_core_tb_top
